// >>> hdl/hrs_result_store.sv
// harmonic result storage: result registers with gain, offset and ratio clamping
// Summary of operation
// - fundamental P, Q, S in 24-bit registers
// - nine harmonic power registers, three per harmonic
// - harmonic powers scaled by signed gain register
// - gain word: sign extended to 28, zero top
// - per-harmonic offset added to P and Q
// - fundamental and three harmonic power factors stored
// - total distortion 3.21, clamped at +3.9999
// - per-harmonic distortion 3.21, clamped likewise
// - neutral mode updates only harmonic rms registers, plus per-harmonic distortion registers when first index is one
// - phase mode: fundamental rms always updated
// - neutral fundamental only via index of one
// - passband 2800 Hz, -3 dB at 3.3 kHz
// - neutral: current rms and current-sum rms mapping
// - neutral mode leaves fundamental rms untouched
// - neutral distortion only when first index one
// - neutral y/z distortions: current and sum
// - neutral first-harmonic distortions read unity 0x1fffff
// - channel select: A, B, C, or neutral
// - three 8-bit harmonic index registers
`timescale 1ns/1ps
`include "hrs_defines.svh"
module hrs_result_store
  import hrs_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic result_update,
  input wire logic [1:0] analysed_channel_select,
  input wire logic [7:0] first_harmonic_index,
  input wire logic [7:0] second_harmonic_index,
  input wire logic [7:0] third_harmonic_index,
  input wire logic signed [23:0] harm_power_gain,
  input wire logic signed [23:0] harm_x_active_offset,
  input wire logic signed [23:0] harm_y_active_offset,
  input wire logic signed [23:0] harm_z_active_offset,
  input wire logic signed [23:0] harm_x_reactive_offset,
  input wire logic signed [23:0] harm_y_reactive_offset,
  input wire logic signed [23:0] harm_z_reactive_offset,
  input wire logic signed [23:0] eng_fund_p,
  input wire logic signed [23:0] eng_fund_q,
  input wire logic signed [23:0] eng_fund_s,
  input wire logic signed [23:0] eng_x_p,
  input wire logic signed [23:0] eng_x_q,
  input wire logic signed [23:0] eng_x_s,
  input wire logic signed [23:0] eng_y_p,
  input wire logic signed [23:0] eng_y_q,
  input wire logic signed [23:0] eng_y_s,
  input wire logic signed [23:0] eng_z_p,
  input wire logic signed [23:0] eng_z_q,
  input wire logic signed [23:0] eng_z_s,
  input wire logic signed [23:0] eng_fund_pf,
  input wire logic signed [23:0] eng_x_pf,
  input wire logic signed [23:0] eng_y_pf,
  input wire logic signed [23:0] eng_z_pf,
  input wire logic [31:0] eng_v_thd,
  input wire logic [31:0] eng_i_thd,
  input wire logic [31:0] eng_x_vhd,
  input wire logic [31:0] eng_x_ihd,
  input wire logic [31:0] eng_y_vhd,
  input wire logic [31:0] eng_y_ihd,
  input wire logic [31:0] eng_z_vhd,
  input wire logic [31:0] eng_z_ihd,
  input wire logic signed [23:0] eng_fund_i_rms,
  input wire logic signed [23:0] eng_fund_v_rms,
  input wire logic signed [23:0] eng_x_i_rms,
  input wire logic signed [23:0] eng_y_i_rms,
  input wire logic signed [23:0] eng_z_i_rms,
  input wire logic signed [23:0] eng_x_v_rms,
  input wire logic signed [23:0] eng_y_v_rms,
  input wire logic signed [23:0] eng_z_v_rms,
  output logic signed [23:0] fund_active_power,
  output logic signed [23:0] fund_reactive_power,
  output logic signed [23:0] fund_apparent_power,
  output logic signed [23:0] harm_x_active_power,
  output logic signed [23:0] harm_x_reactive_power,
  output logic signed [23:0] harm_x_apparent_power,
  output logic signed [23:0] harm_y_active_power,
  output logic signed [23:0] harm_y_reactive_power,
  output logic signed [23:0] harm_y_apparent_power,
  output logic signed [23:0] harm_z_active_power,
  output logic signed [23:0] harm_z_reactive_power,
  output logic signed [23:0] harm_z_apparent_power,
  output logic [31:0] harm_power_gain_word,
  output logic signed [23:0] fund_power_factor,
  output logic signed [23:0] harm_x_power_factor,
  output logic signed [23:0] harm_y_power_factor,
  output logic signed [23:0] harm_z_power_factor,
  output logic [23:0] voltage_total_distortion,
  output logic [23:0] current_total_distortion,
  output logic [23:0] harm_x_volt_distortion,
  output logic [23:0] harm_x_curr_distortion,
  output logic [23:0] harm_y_volt_distortion,
  output logic [23:0] harm_y_curr_distortion,
  output logic [23:0] harm_z_volt_distortion,
  output logic [23:0] harm_z_curr_distortion,
  output logic signed [23:0] fund_current_rms,
  output logic signed [23:0] fund_voltage_rms,
  output logic signed [23:0] harm_x_current_rms,
  output logic signed [23:0] harm_y_current_rms,
  output logic signed [23:0] harm_z_current_rms,
  output logic signed [23:0] harm_x_voltage_rms,
  output logic signed [23:0] harm_y_voltage_rms,
  output logic signed [23:0] harm_z_voltage_rms
);

  // gain is a fraction added to unity, so the reset gain of zero passes results through;
  // the scaled term keeps the product's own sign bit, since min times min is positive
  function automatic hrs_word_t hrs_scale(input hrs_word_t v, input hrs_word_t g, input hrs_word_t os);
    logic signed [47:0] prod;
    logic signed [25:0] sum;
    prod = v * g;
    sum = {{2{v[23]}}, v} + {prod[47], prod[47:`HRS_GAIN_FRAC]} + {{2{os[23]}}, os};
    if (sum > 26'sh07fffff) begin
      hrs_scale = 24'sh7fffff;
    end else if (sum < -26'sh0800000) begin
      hrs_scale = -24'sh800000;
    end else begin
      hrs_scale = sum[23:0];
    end
  endfunction

  // ratios arrive unsigned with 21 fraction bits; anything past the 3.21 ceiling saturates
  function automatic logic [23:0] hrs_clamp(input hrs_raw_ratio_t r);
    if (r > {8'h00, `HRS_DIST_MAX}) begin
      hrs_clamp = `HRS_DIST_MAX;
    end else begin
      hrs_clamp = r[23:0];
    end
  endfunction

  // channel decode
  // channel select decode
  wire hrs_chan_t chan_sel = hrs_chan_t'(analysed_channel_select);
  wire neutral_mode = (chan_sel == HRS_CHAN_NEUTRAL);
  wire upd_phase = result_update && !neutral_mode;
  wire upd_neutral = result_update && neutral_mode;
  wire first_is_fund = (first_harmonic_index == `HRS_INDEX_FUND);
  wire upd_neutral_hd = upd_neutral && first_is_fund;

  // harmonic power datapath: gain on all three, offset on P and Q only
  // gain scaling of harmonic powers
  wire hrs_word_t x_p_d = hrs_scale(eng_x_p, harm_power_gain, harm_x_active_offset);
  wire hrs_word_t x_q_d = hrs_scale(eng_x_q, harm_power_gain, harm_x_reactive_offset);
  wire hrs_word_t x_s_d = hrs_scale(eng_x_s, harm_power_gain, `HRS_RESULT_RST);
  wire hrs_word_t y_p_d = hrs_scale(eng_y_p, harm_power_gain, harm_y_active_offset);
  wire hrs_word_t y_q_d = hrs_scale(eng_y_q, harm_power_gain, harm_y_reactive_offset);
  wire hrs_word_t y_s_d = hrs_scale(eng_y_s, harm_power_gain, `HRS_RESULT_RST);
  wire hrs_word_t z_p_d = hrs_scale(eng_z_p, harm_power_gain, harm_z_active_offset);
  wire hrs_word_t z_q_d = hrs_scale(eng_z_q, harm_power_gain, harm_z_reactive_offset);
  wire hrs_word_t z_s_d = hrs_scale(eng_z_s, harm_power_gain, `HRS_RESULT_RST);

  wire [31:0] gain_word_d = {{`HRS_GAIN_PAD_BITS{1'b0}},
                             {`HRS_GAIN_PAD_BITS{harm_power_gain[`HRS_GAIN_SIGN_BIT]}}, harm_power_gain};

  // clamped ratios
  // total and per-harmonic distortion clamp
  wire [23:0] v_thd_d = hrs_clamp(eng_v_thd);
  wire [23:0] i_thd_d = hrs_clamp(eng_i_thd);
  wire [23:0] x_vhd_d = hrs_clamp(eng_x_vhd);
  wire [23:0] x_ihd_d = hrs_clamp(eng_x_ihd);
  wire [23:0] y_vhd_d = hrs_clamp(eng_y_vhd);
  wire [23:0] y_ihd_d = hrs_clamp(eng_y_ihd);
  wire [23:0] z_vhd_d = hrs_clamp(eng_z_vhd);
  wire [23:0] z_ihd_d = hrs_clamp(eng_z_ihd);

  // gain word mirrors the gain register every cycle
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      harm_power_gain_word <= `HRS_GAIN_WORD_RST;
    end else begin
      harm_power_gain_word <= gain_word_d;
    end
  end

  // power results only move in phase mode
  // powers frozen in neutral
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      fund_active_power <= `HRS_RESULT_RST;
      fund_reactive_power <= `HRS_RESULT_RST;
      fund_apparent_power <= `HRS_RESULT_RST;
    end else if (upd_phase) begin
      fund_active_power <= eng_fund_p;
      fund_reactive_power <= eng_fund_q;
      fund_apparent_power <= eng_fund_s;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      harm_x_active_power <= `HRS_RESULT_RST;
      harm_x_reactive_power <= `HRS_RESULT_RST;
      harm_x_apparent_power <= `HRS_RESULT_RST;
      harm_y_active_power <= `HRS_RESULT_RST;
      harm_y_reactive_power <= `HRS_RESULT_RST;
      harm_y_apparent_power <= `HRS_RESULT_RST;
      harm_z_active_power <= `HRS_RESULT_RST;
      harm_z_reactive_power <= `HRS_RESULT_RST;
      harm_z_apparent_power <= `HRS_RESULT_RST;
    end else if (upd_phase) begin
      harm_x_active_power <= x_p_d;
      harm_x_reactive_power <= x_q_d;
      harm_x_apparent_power <= x_s_d;
      harm_y_active_power <= y_p_d;
      harm_y_reactive_power <= y_q_d;
      harm_y_apparent_power <= y_s_d;
      harm_z_active_power <= z_p_d;
      harm_z_reactive_power <= z_q_d;
      harm_z_apparent_power <= z_s_d;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      fund_power_factor <= `HRS_RESULT_RST;
      harm_x_power_factor <= `HRS_RESULT_RST;
      harm_y_power_factor <= `HRS_RESULT_RST;
      harm_z_power_factor <= `HRS_RESULT_RST;
    end else if (upd_phase) begin
      fund_power_factor <= eng_fund_pf;
      harm_x_power_factor <= eng_x_pf;
      harm_y_power_factor <= eng_y_pf;
      harm_z_power_factor <= eng_z_pf;
    end
  end

  // total distortion needs the phase rms, so it has no neutral meaning
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      voltage_total_distortion <= `HRS_RESULT_RST;
      current_total_distortion <= `HRS_RESULT_RST;
    end else if (upd_phase) begin
      voltage_total_distortion <= v_thd_d;
      current_total_distortion <= i_thd_d;
    end
  end

  // per-harmonic distortions; neutral without index one holds, avoiding undefined ratios
  // neutral y/z distortion mapping
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      harm_y_volt_distortion <= `HRS_RESULT_RST;
      harm_y_curr_distortion <= `HRS_RESULT_RST;
      harm_z_volt_distortion <= `HRS_RESULT_RST;
      harm_z_curr_distortion <= `HRS_RESULT_RST;
    end else if (upd_phase || upd_neutral_hd) begin
      harm_y_volt_distortion <= y_vhd_d;
      harm_y_curr_distortion <= y_ihd_d;
      harm_z_volt_distortion <= z_vhd_d;
      harm_z_curr_distortion <= z_ihd_d;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      harm_x_volt_distortion <= `HRS_RESULT_RST;
      harm_x_curr_distortion <= `HRS_RESULT_RST;
    end else if (upd_neutral_hd) begin
      harm_x_volt_distortion <= `HRS_DIST_UNITY;
      harm_x_curr_distortion <= `HRS_DIST_UNITY;
    end else if (upd_phase) begin
      harm_x_volt_distortion <= x_vhd_d;
      harm_x_curr_distortion <= x_ihd_d;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      fund_current_rms <= `HRS_RESULT_RST;
      fund_voltage_rms <= `HRS_RESULT_RST;
    end else if (upd_phase) begin
      fund_current_rms <= eng_fund_i_rms;
      fund_voltage_rms <= eng_fund_v_rms;
    end
  end

  // in neutral mode the voltage inputs carry the phase-current-sum results
  // neutral rms mapping
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      harm_x_current_rms <= `HRS_RESULT_RST;
      harm_y_current_rms <= `HRS_RESULT_RST;
      harm_z_current_rms <= `HRS_RESULT_RST;
      harm_x_voltage_rms <= `HRS_RESULT_RST;
      harm_y_voltage_rms <= `HRS_RESULT_RST;
      harm_z_voltage_rms <= `HRS_RESULT_RST;
    end else if (result_update) begin
      harm_x_current_rms <= eng_x_i_rms;
      harm_y_current_rms <= eng_y_i_rms;
      harm_z_current_rms <= eng_z_i_rms;
      harm_x_voltage_rms <= eng_x_v_rms;
      harm_y_voltage_rms <= eng_y_v_rms;
      harm_z_voltage_rms <= eng_z_v_rms;
    end
  end

  // checks
  sequence s_upd_neutral;
    result_update && (analysed_channel_select == HRS_CHAN_NEUTRAL);
  endsequence
  sequence s_upd_phase;
    result_update && (analysed_channel_select != HRS_CHAN_NEUTRAL);
  endsequence

  property p_fund_power;
    @(posedge clock) disable iff (!rst_b) s_upd_phase |=> fund_active_power == $past(eng_fund_p);
  endproperty
  a_fund_power: assert property (p_fund_power) else $error("fundamental power not stored");

  property p_harm_power;
    @(posedge clock) disable iff (!rst_b)
      s_upd_phase and (harm_power_gain == 24'sh000000 && harm_x_active_offset == 24'sh000000)
      |=> harm_x_active_power == $past(eng_x_p) && harm_y_apparent_power == $past(eng_y_s);
  endproperty
  a_harm_power: assert property (p_harm_power) else $error("harmonic power wrong at unity gain");

  property p_gain_half;
    @(posedge clock) disable iff (!rst_b)
      s_upd_phase and (harm_power_gain == 24'sh400000 && eng_z_s == 24'sh000100)
      |=> harm_z_apparent_power == 24'sh000180;
  endproperty
  a_gain_half: assert property (p_gain_half) else $error("gain scaling wrong");

  property p_gain_word;
    @(posedge clock) disable iff (!rst_b) 1'b1 |=> harm_power_gain_word[31:28] == 4'h0
      && harm_power_gain_word[27:24] == {4{$past(harm_power_gain[23])}};
  endproperty
  a_gain_word: assert property (p_gain_word) else $error("gain word layout wrong");

  property p_offset;
    @(posedge clock) disable iff (!rst_b)
      s_upd_phase and (harm_power_gain == 24'sh000000 && eng_y_q == 24'sh000000
      && harm_y_reactive_offset == 24'sh000010) |=> harm_y_reactive_power == 24'sh000010;
  endproperty
  a_offset: assert property (p_offset) else $error("offset not added");

  property p_clamp;
    @(posedge clock) disable iff (!rst_b)
      s_upd_phase and (eng_v_thd > 32'h007fffff) |=> voltage_total_distortion == 24'h7fffff;
  endproperty
  a_clamp: assert property (p_clamp) else $error("total distortion not clamped");

  property p_neutral_frozen;
    @(posedge clock) disable iff (!rst_b)
      s_upd_neutral |=> $stable(fund_power_factor) && $stable(harm_z_active_power) && $stable(fund_current_rms);
  endproperty
  a_neutral_frozen: assert property (p_neutral_frozen) else $error("power or fund rms moved in neutral");

  property p_neutral_rms;
    @(posedge clock) disable iff (!rst_b)
      s_upd_neutral |=> harm_x_current_rms == $past(eng_x_i_rms) && harm_z_voltage_rms == $past(eng_z_v_rms);
  endproperty
  a_neutral_rms: assert property (p_neutral_rms) else $error("neutral rms not stored");

  property p_unity;
    @(posedge clock) disable iff (!rst_b)
      s_upd_neutral and (first_harmonic_index == 8'h01) |=> harm_x_volt_distortion == 24'h1fffff
      && harm_x_curr_distortion == 24'h1fffff && harm_y_curr_distortion == $past(y_ihd_d);
  endproperty
  a_unity: assert property (p_unity) else $error("neutral unity distortion missing");

  property p_hd_hold;
    @(posedge clock) disable iff (!rst_b)
      s_upd_neutral and (first_harmonic_index != 8'h01) |=> $stable(harm_y_volt_distortion)
      && $stable(harm_x_curr_distortion);
  endproperty
  a_hd_hold: assert property (p_hd_hold) else $error("distortion moved without index one");

endmodule

// >>> hdl/hrs_defines.svh
// constants for the harmonic result storage block
`ifndef HRS_DEFINES_SVH
`define HRS_DEFINES_SVH
`define HRS_RESULT_RST 24'h000000
`define HRS_GAIN_WORD_RST 32'h00000000
`define HRS_DIST_MAX 24'h7fffff
`define HRS_DIST_UNITY 24'h1fffff
`define HRS_INDEX_FUND 8'h01
`define HRS_INDEX_MAX 8'h3f
`define HRS_GAIN_FRAC 23
`define HRS_GAIN_SIGN_BIT 23
`define HRS_GAIN_PAD_BITS 4
`define HRS_PASSBAND_HZ 2800
`define HRS_BANDWIDTH_3DB_HZ 3300
`endif

// >>> hdl/hrs_pkg.sv
// types for the harmonic result storage block
package hrs_pkg;
  typedef enum logic [1:0] {
    HRS_CHAN_A = 2'b00,
    HRS_CHAN_B = 2'b01,
    HRS_CHAN_C = 2'b10,
    HRS_CHAN_NEUTRAL = 2'b11
  } hrs_chan_t;
  typedef logic signed [23:0] hrs_word_t;
  typedef logic [31:0] hrs_raw_ratio_t;
endpackage

// >>> test/hrs_result_store_tb.sv
// self-checking bench for the harmonic result storage block, with a reference model
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
  check_count++; \
  if ((g) !== (e)) begin \
    fail_count++; \
    $display("FAIL %s expected %h seen %h", nm, e, g); \
  end \
end
module hrs_result_store_tb
  import hrs_pkg::*;
;
  logic clock;
  logic rst_b;
  logic result_update;
  logic [1:0] sel;
  logic [7:0] idx1, idx2, idx3;
  logic [23:0] harm_power_gain;
  logic [23:0] ev [24];
  logic [31:0] er [8];
  logic [23:0] off [6];
  wire [23:0] got [32];
  wire [31:0] gw;
  logic [23:0] exp_r [32];
  logic [31:0] exp_gw;
  bit chk_on;
  int fail_count;
  int check_count;

  hrs_result_store hrs_result_store_i (
    .clock, .rst_b, .result_update, .analysed_channel_select(sel), .first_harmonic_index(idx1),
    .second_harmonic_index(idx2), .third_harmonic_index(idx3), .harm_power_gain,
    .harm_x_active_offset(off[0]), .harm_y_active_offset(off[1]), .harm_z_active_offset(off[2]),
    .harm_x_reactive_offset(off[3]), .harm_y_reactive_offset(off[4]), .harm_z_reactive_offset(off[5]),
    .eng_fund_p(ev[0]), .eng_fund_q(ev[1]), .eng_fund_s(ev[2]), .eng_x_p(ev[3]), .eng_x_q(ev[4]),
    .eng_x_s(ev[5]), .eng_y_p(ev[6]), .eng_y_q(ev[7]), .eng_y_s(ev[8]), .eng_z_p(ev[9]), .eng_z_q(ev[10]),
    .eng_z_s(ev[11]), .eng_fund_pf(ev[12]), .eng_x_pf(ev[13]), .eng_y_pf(ev[14]), .eng_z_pf(ev[15]),
    .eng_v_thd(er[0]), .eng_i_thd(er[1]), .eng_x_vhd(er[2]), .eng_x_ihd(er[3]), .eng_y_vhd(er[4]),
    .eng_y_ihd(er[5]), .eng_z_vhd(er[6]), .eng_z_ihd(er[7]), .eng_fund_i_rms(ev[16]),
    .eng_fund_v_rms(ev[17]), .eng_x_i_rms(ev[18]), .eng_y_i_rms(ev[19]), .eng_z_i_rms(ev[20]),
    .eng_x_v_rms(ev[21]), .eng_y_v_rms(ev[22]), .eng_z_v_rms(ev[23]),
    .fund_active_power(got[0]), .fund_reactive_power(got[1]), .fund_apparent_power(got[2]),
    .harm_x_active_power(got[3]), .harm_x_reactive_power(got[4]), .harm_x_apparent_power(got[5]),
    .harm_y_active_power(got[6]), .harm_y_reactive_power(got[7]), .harm_y_apparent_power(got[8]),
    .harm_z_active_power(got[9]), .harm_z_reactive_power(got[10]), .harm_z_apparent_power(got[11]),
    .harm_power_gain_word(gw), .fund_power_factor(got[12]), .harm_x_power_factor(got[13]),
    .harm_y_power_factor(got[14]), .harm_z_power_factor(got[15]), .voltage_total_distortion(got[16]),
    .current_total_distortion(got[17]), .harm_x_volt_distortion(got[18]), .harm_x_curr_distortion(got[19]),
    .harm_y_volt_distortion(got[20]), .harm_y_curr_distortion(got[21]), .harm_z_volt_distortion(got[22]),
    .harm_z_curr_distortion(got[23]), .fund_current_rms(got[24]), .fund_voltage_rms(got[25]),
    .harm_x_current_rms(got[26]), .harm_y_current_rms(got[27]), .harm_z_current_rms(got[28]),
    .harm_x_voltage_rms(got[29]), .harm_y_voltage_rms(got[30]), .harm_z_voltage_rms(got[31])
  );

  // scaled harmonic power: gain as 1 + g/2^23, offset after, saturated to 24 bits signed
  function automatic logic [23:0] hp(input logic [23:0] v, input logic [23:0] o);
    longint r;
    r = longint'($signed(v)) + ((longint'($signed(v)) * longint'($signed(harm_power_gain))) >>> 23);
    r = r + longint'($signed(o));
    if (r > 64'sd8388607) r = 64'sd8388607;
    if (r < -64'sd8388608) r = -64'sd8388608;
    return r[23:0];
  endfunction

  // ratio clamp at the largest positive 3.21 code
  function automatic logic [23:0] cl(input logic [31:0] r);
    return (r > 32'h007fffff) ? 24'h7fffff : r[23:0];
  endfunction

  // random 24-bit value, or a corner: 1 all max, 2 all min
  function automatic logic [23:0] rv(input int c);
    return (c == 1) ? 24'h7fffff : (c == 2) ? 24'h800000 : 24'($urandom);
  endfunction

  // clock at 100 ns period
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // reference model: samples the same edge as the design, so back-to-back updates line up
  always @(posedge clock) begin
    exp_gw <= rst_b ? {4'h0, {4{harm_power_gain[23]}}, harm_power_gain} : 32'h0;
    if (!rst_b) begin
      for (int i = 0; i < 32; i++) exp_r[i] <= 24'h0;
    end else if (result_update && sel != HRS_CHAN_NEUTRAL) begin
      for (int i = 0; i < 3; i++) exp_r[i] <= ev[i];
      for (int i = 12; i < 16; i++) exp_r[i] <= ev[i];
      // harmonic powers, offsets on active and reactive only
      for (int k = 0; k < 3; k++) begin
        exp_r[3 + 3 * k] <= hp(ev[3 + 3 * k], off[k]);
        exp_r[4 + 3 * k] <= hp(ev[4 + 3 * k], off[3 + k]);
        exp_r[5 + 3 * k] <= hp(ev[5 + 3 * k], 24'h0);
      end
      for (int i = 0; i < 8; i++) exp_r[16 + i] <= cl(er[i]);
      for (int i = 16; i < 24; i++) exp_r[8 + i] <= ev[i];
    end else if (result_update) begin
      for (int i = 18; i < 24; i++) exp_r[8 + i] <= ev[i];
      // distortions only with first index at one
      if (idx1 == 8'h01) begin
        exp_r[18] <= 24'h1fffff;
        exp_r[19] <= 24'h1fffff;
        for (int i = 4; i < 8; i++) exp_r[16 + i] <= cl(er[i]);
      end
    end
  end

  // compare every register on the falling edge, once the first reset edge has passed
  always @(negedge clock) begin
    if (chk_on) begin
      for (int i = 0; i < 32; i++) `CHK($sformatf("result %0d", i), exp_r[i], got[i])
      `CHK("gain word", exp_gw, gw)
    end
  end

  // one engine cycle; c picks a corner set, 3 puts ratios around the clamp point
  task automatic step(input logic [1:0] s, input logic [7:0] h, input bit u, input int c);
    @(posedge clock);
    for (int i = 0; i < 24; i++) ev[i] <= rv(c);
    for (int i = 0; i < 6; i++) off[i] <= rv(c);
    for (int i = 0; i < 8; i++) er[i] <= (c == 3) ? 32'h007ffffb + 32'(i) : $urandom >> ($urandom % 32);
    harm_power_gain <= rv(c);
    sel <= s;
    idx1 <= h;
    // indexes kept at 63 or below
    idx2 <= 8'($urandom % 64);
    idx3 <= 8'($urandom % 64);
    result_update <= u;
  endtask

  // a run of cycles, most of them updates, ending idle so held values are seen
  task automatic burst(input int n, input logic [1:0] s, input logic [7:0] h, input int c);
    for (int i = 0; i < n; i++) step(s, h, ($urandom % 4) != 0, c);
    step(s, h, 1'b0, 0);
  endtask

  task automatic tdone(input string nm);
    @(negedge clock);
    $display("test %s done", nm);
  endtask

  task tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // watchdog: the tests need about 100 cycles
  initial begin
    repeat (2000) @(posedge clock);
    fail_count++;
    $display("FAIL watchdog expired");
    tally_and_finish();
  end

  // main sequence
  initial begin
    rst_b = 1'b0;
    result_update = 1'b0;
    sel = 2'b00;
    idx1 = 8'h0;
    idx2 = 8'h0;
    idx3 = 8'h0;
    harm_power_gain = 24'h0;
    for (int i = 0; i < 24; i++) ev[i] = 24'h0;
    for (int i = 0; i < 8; i++) er[i] = 32'h0;
    for (int i = 0; i < 6; i++) off[i] = 24'h0;
    void'($urandom(32'hb9d43db5));
    @(posedge clock);
    chk_on <= 1'b1;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    // phases A, B and C analysed
    for (int s = 0; s < 3; s++) burst(10, 2'(s), 8'($urandom % 64), 0);
    tdone("phase");
    // saturation corners and ratio clamp boundary
    burst(3, 2'b00, 8'h02, 1);
    burst(3, 2'b01, 8'h02, 2);
    burst(3, 2'b10, 8'h02, 3);
    // directed: gain of one and a half on a small apparent power
    @(posedge clock);
    result_update <= 1'b1;
    sel <= 2'b00;
    harm_power_gain <= 24'h400000;
    ev[11] <= 24'h000100;
    // directed: unity gain, bare y reactive offset, no x active offset
    @(posedge clock);
    harm_power_gain <= 24'h000000;
    ev[7] <= 24'h000000;
    off[0] <= 24'h000000;
    off[4] <= 24'h000010;
    step(2'b00, 8'h02, 1'b0, 0);
    tdone("corners");
    // neutral with fundamental on the first index
    burst(12, 2'b11, 8'h01, 0);
    burst(2, 2'b11, 8'h01, 3);
    tdone("neutral_fund");
    burst(4, 2'b11, 8'h00, 0);
    burst(4, 2'b11, 8'h02, 0);
    burst(4, 2'b11, 8'h3f, 0);
    tdone("neutral_nofund");
    // reset in mid-run, updates offered while held, then both modes again
    burst(3, 2'b00, 8'h05, 0);
    @(posedge clock);
    rst_b <= 1'b0;
    burst(2, 2'b01, 8'h03, 0);
    @(posedge clock);
    rst_b <= 1'b1;
    burst(4, 2'b11, 8'h01, 0);
    burst(3, 2'b01, 8'h07, 0);
    tdone("reset");
    tally_and_finish();
  end
endmodule
